// *** mac_defines.svh ***
// constants for the multiply-accumulate unit
`ifndef MAC_DEFINES_SVH
`define MAC_DEFINES_SVH
`define MAC_ACC_RST 48'h0000_0000_0000
`define MAC_WORD_RST 16'h0000
`define MAC_OPC_ACC_MIXED 16'hBE16
`define MAC_OPC_ACC_SIGNED 16'hB017
`define MAC_OPC_ACC_UNSIGNED 16'hB016
`define MAC_OPC_PROD_MIXED 16'hB013
`define MAC_OPC_PROD_SIGNED 16'hB097
`define MAC_OPC_PROD_UNSIGNED 16'hB096
`define MAC_OPC_PROD_SUB 16'hBE96
`define MAC_OPC_RD_EXT 16'hBE12
`define MAC_OPC_WR_EXT 16'hBE92
`define MAC_OPC_LEADING_ZERO_NORMALISE 16'hB00F
`define MAC_OPC_RSHIFT 16'hB011
`define MAC_OPC_STREAM_BUS 16'hB092
`define MAC_OPC_STREAM_STK 16'hB012
`define MAC_OPC_RD_MID 16'hBE17
`define MAC_OPC_RD_LOW 16'hBE16
`define MAC_OPC_FETCH 16'hE842
// return bit and interrupt bit masked out of selection
`define MAC_OPC_MASK 16'hFEDF
`define MAC_OPC_FETCH_MASK 16'hFFE0
`endif

// *** mac_pkg.sv ***
// types for the multiply-accumulate unit
package mac_pkg;
	typedef enum logic [3:0] {
		MAC_NOP = 4'h0,
		MAC_ACC_MIXED = 4'h1,
		MAC_ACC_SIGNED = 4'h2,
		MAC_ACC_UNSIGNED = 4'h3,
		MAC_PROD_MIXED = 4'h4,
		MAC_PROD_SIGNED = 4'h5,
		MAC_PROD_UNSIGNED = 4'h6,
		MAC_PROD_SUB = 4'h7,
		MAC_RD_EXT = 4'h8,
		MAC_WR_EXT = 4'h9,
		MAC_LEADING_ZERO_NORMALISE = 4'hA,
		MAC_RSHIFT = 4'hB,
		MAC_STREAM = 4'hC,
		MAC_RD_MID = 4'hD,
		MAC_RD_LOW = 4'hE,
		MAC_FETCH = 4'hF
	} mac_cmd_e;
	typedef enum logic [1:0] {
		MAC_IDLE = 2'b00,
		MAC_ARMED = 2'b01,
		MAC_STREAMING = 2'b10
	} mac_state_e;
endpackage

// *** mac_stack_model.sv ***
// processor stack registers that feed and follow the unit
`timescale 1ns/1ps
module mac_stack_model (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic load_i,
	input wire logic [15:0] load_top_i,
	input wire logic [15:0] load_next_i,
	input wire logic push_i,
	input wire logic pop_i,
	input wire logic top_we_i,
	input wire logic [15:0] new_top_i,
	output logic [15:0] top_o,
	output logic [15:0] next_o
);
	// one stack memory cell is enough for the depths used
	logic [15:0] deep;
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			top_o <= 16'h0000;
			next_o <= 16'h0000;
			deep <= 16'h0000;
		end else if (load_i) begin
			top_o <= load_top_i;
			next_o <= load_next_i;
		end else if (push_i) begin
			deep <= next_o;
			next_o <= top_o;
			top_o <= new_top_i;
		end else if (top_we_i) begin
			next_o <= top_o;
			top_o <= new_top_i;
		end else if (pop_i) begin
			top_o <= next_o;
			next_o <= deep;
		end
	end
endmodule

// *** mac_unit.sv ***
// single-cycle 16x16 multiply-accumulate unit with 48-bit accumulator
`timescale 1ns/1ps
`include "mac_defines.svh"

module mac_unit (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic exec_i,
	input wire logic [15:0] opcode_i,
	input wire logic [15:0] top_i,
	input wire logic [15:0] next_i,
	input wire logic [15:0] stream_data_i,
	output logic [15:0] acc_ext_word_o,
	output logic [15:0] acc_mid_word_o,
	output logic [15:0] acc_low_word_o,
	output logic stack_push_o,
	output logic stack_pop_o,
	output logic [15:0] stack_top_o,
	output logic stack_top_we_o,
	output logic stream_active_o,
	output logic stream_from_bus_o,
	output logic int_hold_o
);

	// return bit (5) and interrupt bit (8) are don't-care for every command but fetch, whose match keeps both bits
	function automatic mac_pkg::mac_cmd_e decode(input logic [15:0] op);
		logic [15:0] m;
		m = op & `MAC_OPC_MASK;
		if ((op & `MAC_OPC_FETCH_MASK) == (`MAC_OPC_FETCH & `MAC_OPC_FETCH_MASK))
			decode = mac_pkg::MAC_FETCH;
		else if (m == (`MAC_OPC_ACC_MIXED & `MAC_OPC_MASK))
			decode = mac_pkg::MAC_ACC_MIXED;
		else if (m == (`MAC_OPC_ACC_SIGNED & `MAC_OPC_MASK))
			decode = mac_pkg::MAC_ACC_SIGNED;
		else if (m == (`MAC_OPC_ACC_UNSIGNED & `MAC_OPC_MASK))
			decode = mac_pkg::MAC_ACC_UNSIGNED;
		else if (m == (`MAC_OPC_PROD_MIXED & `MAC_OPC_MASK))
			decode = mac_pkg::MAC_PROD_MIXED;
		else if (m == (`MAC_OPC_PROD_SIGNED & `MAC_OPC_MASK))
			decode = mac_pkg::MAC_PROD_SIGNED;
		else if (m == (`MAC_OPC_PROD_UNSIGNED & `MAC_OPC_MASK))
			decode = mac_pkg::MAC_PROD_UNSIGNED;
		else if (m == (`MAC_OPC_PROD_SUB & `MAC_OPC_MASK))
			decode = mac_pkg::MAC_PROD_SUB;
		else if (m == (`MAC_OPC_RD_EXT & `MAC_OPC_MASK))
			decode = mac_pkg::MAC_RD_EXT;
		else if (m == (`MAC_OPC_WR_EXT & `MAC_OPC_MASK))
			decode = mac_pkg::MAC_WR_EXT;
		else if (m == (`MAC_OPC_LEADING_ZERO_NORMALISE & `MAC_OPC_MASK))
			decode = mac_pkg::MAC_LEADING_ZERO_NORMALISE;
		else if (m == (`MAC_OPC_RSHIFT & `MAC_OPC_MASK))
			decode = mac_pkg::MAC_RSHIFT;
		else if (m == (`MAC_OPC_STREAM_BUS & `MAC_OPC_MASK))
			decode = mac_pkg::MAC_STREAM;
		else if (m == (`MAC_OPC_RD_MID & `MAC_OPC_MASK))
			decode = mac_pkg::MAC_RD_MID;
		else
			decode = mac_pkg::MAC_NOP;
	endfunction

	// 17-bit signed operands cover all three sign modes
	function automatic logic [47:0] product(input logic [15:0] a, input logic [15:0] b,
		input logic a_signed, input logic b_signed);
		logic signed [16:0] sa;
		logic signed [16:0] sb;
		logic signed [33:0] p;
		sa = {a_signed & a[15], a};
		sb = {b_signed & b[15], b};
		p = sa * sb;
		product = {{14{p[33]}}, p};
	endfunction

	// accumulator and streamed-state flops
	logic [47:0] acc;
	logic [47:0] next_acc;
	mac_pkg::mac_state_e state;
	mac_pkg::mac_state_e next_state;
	logic from_bus;
	logic next_from_bus;
	logic [15:0] pipe;
	logic [15:0] next_pipe;

	// stack strobes and interrupt hold are one-cycle pulses; the stack top value keeps its value
	logic push;
	logic next_push;
	logic pop;
	logic next_pop;
	logic [15:0] tout;
	logic [15:0] next_tout;
	logic twe;
	logic next_twe;
	logic hold;
	logic next_hold;

	// decode and normalise datapath
	mac_pkg::mac_cmd_e cmd;
	logic [31:0] dword;
	logic [4:0] lz;
	logic [31:0] shifted;
	logic lz_found;

	// shared multiplier operands and its sign-extended result
	logic [15:0] mul_a;
	logic [15:0] mul_b;
	logic mul_a_signed;
	logic mul_b_signed;
	logic [47:0] prod_ext;

	assign cmd = exec_i ? decode(opcode_i) : mac_pkg::MAC_NOP;
	assign dword = {top_i, next_i};

	// one array for every command: area of a single 17x17 multiplier for an operand mux
	always_comb begin
		mul_a = top_i;
		mul_b = next_i;
		mul_a_signed = 1'b1;
		mul_b_signed = 1'b1;
		if (cmd == mac_pkg::MAC_FETCH) begin
			// streamed fetch multiplies next by the pipelined source word
			mul_a = next_i;
			mul_b = pipe;
		end else if (cmd == mac_pkg::MAC_ACC_UNSIGNED
			|| cmd == mac_pkg::MAC_PROD_UNSIGNED) begin
			mul_a_signed = 1'b0;
			mul_b_signed = 1'b0;
		end else if (cmd == mac_pkg::MAC_ACC_MIXED
			|| cmd == mac_pkg::MAC_PROD_MIXED) begin
			// top keeps its sign, next is taken as unsigned
			mul_b_signed = 1'b0;
		end
	end

	assign prod_ext = product(mul_a, mul_b, mul_a_signed, mul_b_signed);

	always_comb begin
		lz = 5'h00;
		lz_found = 1'b0;
		for (int i = 31; i >= 0; i--) begin
			if (!lz_found && dword[i]) begin
				lz_found = 1'b1;
				lz = 5'(31 - i);
			end
		end
		// all-zero operand: count saturates at 31, value stays zero
		if (!lz_found)
			lz = 5'h1F;
		shifted = dword << lz;
	end

	always_comb begin
		next_acc = acc;
		next_state = state;
		next_from_bus = from_bus;
		next_pipe = stream_data_i;
		next_push = 1'b0;
		next_pop = 1'b0;
		next_tout = tout;
		next_twe = 1'b0;
		next_hold = 1'b0;
		// streamed state lasts until the first non-fetch instruction
		unique case (state)
			mac_pkg::MAC_IDLE: begin
			end
			mac_pkg::MAC_ARMED: begin
				// whatever follows setup is the count instruction; it opens the stream
				if (exec_i)
					next_state = mac_pkg::MAC_STREAMING;
			end
			mac_pkg::MAC_STREAMING: begin
				if (exec_i && cmd != mac_pkg::MAC_FETCH)
					next_state = mac_pkg::MAC_IDLE;
			end
			// unused code 2'b11 falls back to idle
			default:
				next_state = mac_pkg::MAC_IDLE;
		endcase
		unique case (cmd)
			mac_pkg::MAC_NOP: begin
			end
			mac_pkg::MAC_ACC_MIXED:
				next_acc = acc + prod_ext;
			mac_pkg::MAC_ACC_SIGNED:
				next_acc = acc + prod_ext;
			mac_pkg::MAC_ACC_UNSIGNED:
				next_acc = acc + prod_ext;
			mac_pkg::MAC_PROD_MIXED: begin
				next_acc = {acc[47:32], prod_ext[31:0]};
				next_hold = 1'b1;
			end
			mac_pkg::MAC_PROD_SIGNED: begin
				next_acc = {acc[47:32], prod_ext[31:0]};
				next_hold = 1'b1;
			end
			mac_pkg::MAC_PROD_UNSIGNED: begin
				next_acc = {acc[47:32], prod_ext[31:0]};
				next_hold = 1'b1;
			end
			mac_pkg::MAC_PROD_SUB:
				next_acc = acc - prod_ext;
			mac_pkg::MAC_RD_EXT: begin
				next_tout = acc[47:32];
				next_twe = 1'b1;
				next_push = 1'b1;
			end
			mac_pkg::MAC_WR_EXT: begin
				next_acc = {top_i, acc[31:0]};
				next_pop = 1'b1;
			end
			mac_pkg::MAC_LEADING_ZERO_NORMALISE:
				next_acc = {11'h000, lz, shifted};
			mac_pkg::MAC_RSHIFT:
				next_acc = {{16{acc[47]}}, acc[47:16]};
			mac_pkg::MAC_STREAM: begin
				next_state = mac_pkg::MAC_ARMED;
				next_from_bus = opcode_i[7];
				next_hold = 1'b1;
			end
			mac_pkg::MAC_RD_MID: begin
				// low-word read shares its code point with mixed accumulate
				next_tout = acc[31:16];
				next_twe = 1'b1;
				next_hold = 1'b1;
			end
			mac_pkg::MAC_RD_LOW: begin
				// unreachable while mixed accumulate owns the shared code point
				next_tout = acc[15:0];
				next_twe = 1'b1;
			end
			mac_pkg::MAC_FETCH: begin
				if (state == mac_pkg::MAC_STREAMING)
					next_acc = acc + prod_ext;
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			acc <= `MAC_ACC_RST;
			state <= mac_pkg::MAC_IDLE;
			from_bus <= 1'b0;
			pipe <= `MAC_WORD_RST;
			push <= 1'b0;
			pop <= 1'b0;
			tout <= `MAC_WORD_RST;
			twe <= 1'b0;
			hold <= 1'b0;
		end else begin
			acc <= next_acc;
			state <= next_state;
			from_bus <= next_from_bus;
			pipe <= next_pipe;
			push <= next_push;
			pop <= next_pop;
			tout <= next_tout;
			twe <= next_twe;
			hold <= next_hold;
		end
	end

	// port copies of the accumulator, loaded from the same next value so they
	// never lag the internal register
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			acc_ext_word_o <= `MAC_WORD_RST;
			acc_mid_word_o <= `MAC_WORD_RST;
			acc_low_word_o <= `MAC_WORD_RST;
			stream_active_o <= 1'b0;
		end else begin
			acc_ext_word_o <= next_acc[47:32];
			acc_mid_word_o <= next_acc[31:16];
			acc_low_word_o <= next_acc[15:0];
			stream_active_o <= (next_state == mac_pkg::MAC_STREAMING);
		end
	end

	// strobes last one cycle; int_hold_o trails its instruction by one edge
	assign stack_push_o = push;
	assign stack_pop_o = pop;
	assign stack_top_o = tout;
	assign stack_top_we_o = twe;
	assign stream_from_bus_o = from_bus;
	assign int_hold_o = hold;

endmodule

// *** mac_unit_assertions.sv ***
// port checker for the multiply-accumulate unit
`timescale 1ns/1ps
`include "mac_defines.svh"
module mac_unit_chk (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic exec_i,
	input wire logic [15:0] opcode_i,
	input wire logic [15:0] top_i,
	input wire logic [15:0] next_i,
	input wire logic [15:0] acc_ext_word_o,
	input wire logic [15:0] acc_mid_word_o,
	input wire logic [15:0] acc_low_word_o,
	input wire logic stack_push_o,
	input wire logic stack_pop_o,
	input wire logic [15:0] stack_top_o,
	input wire logic stack_top_we_o,
	input wire logic int_hold_o
);
	logic [15:0] op;
	logic [47:0] acc;
	logic [31:0] ps;
	logic [31:0] pu;
	logic [31:0] pm;
	logic prod;
	logic holds;
	// low 32 bits of a 32x32 product equal the signed 16x16 product
	assign op = exec_i ? (opcode_i & `MAC_OPC_MASK) : 16'h0000;
	assign acc = {acc_ext_word_o, acc_mid_word_o, acc_low_word_o};
	assign ps = {{16{top_i[15]}}, top_i} * {{16{next_i[15]}}, next_i};
	assign pu = {16'h0000, top_i} * {16'h0000, next_i};
	assign pm = {{16{top_i[15]}}, top_i} * {16'h0000, next_i};
	assign prod = op == `MAC_OPC_PROD_SIGNED || op == `MAC_OPC_PROD_UNSIGNED
		|| op == `MAC_OPC_PROD_MIXED;
	assign holds = prod || op == `MAC_OPC_STREAM_BUS || op == `MAC_OPC_RD_MID;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	prod_signed_a: assert property (
		op == `MAC_OPC_PROD_SIGNED |=> acc[31:0] == $past(ps)) else $error("signed product");
	prod_mixed_a: assert property (
		op == `MAC_OPC_PROD_MIXED |=> acc[31:0] == $past(pm)) else $error("mixed product");
	acc_signed_a: assert property (
		op == `MAC_OPC_ACC_SIGNED |=> acc == $past(acc) + {{16{$past(ps[31])}}, $past(ps)})
		else $error("signed accumulate");
	acc_unsigned_a: assert property (
		op == `MAC_OPC_ACC_UNSIGNED |=> acc == $past(acc) + {16'h0000, $past(pu)})
		else $error("unsigned accumulate");
	prod_sub_a: assert property (
		op == `MAC_OPC_PROD_SUB |=> acc == $past(acc) - {{16{$past(ps[31])}}, $past(ps)})
		else $error("product subtract");
	prod_hold_a: assert property (
		prod |=> int_hold_o ##1 (!int_hold_o || $past(holds))) else $error("interrupt hold");
	no_stack_a: assert property (
		prod |=> !(stack_push_o || stack_pop_o || stack_top_we_o)) else $error("stack touched");
	rd_ext_a: assert property (
		op == `MAC_OPC_RD_EXT |=> stack_push_o && stack_top_we_o
		&& stack_top_o == $past(acc_ext_word_o)) else $error("extension read");
	rshift_a: assert property (
		op == `MAC_OPC_RSHIFT |=> acc == {{16{$past(acc[47])}}, $past(acc[47:16])})
		else $error("right shift");
	stream_hold_a: assert property (
		op == `MAC_OPC_STREAM_BUS |=> int_hold_o && !stack_push_o && !stack_pop_o)
		else $error("stream setup hold");
	cover property (op == `MAC_OPC_LEADING_ZERO_NORMALISE);
	cover property (op == `MAC_OPC_WR_EXT ##1 stack_pop_o);
	cover property (op == `MAC_OPC_RD_MID ##1 stack_top_we_o);
endmodule

bind mac_unit mac_unit_chk i_chk (.clk_i, .rst_n_i, .exec_i, .opcode_i, .top_i, .next_i,
	.acc_ext_word_o, .acc_mid_word_o, .acc_low_word_o, .stack_push_o, .stack_pop_o,
	.stack_top_o, .stack_top_we_o, .int_hold_o);

// *** tb.sv ***
// self-checking bench for the multiply-accumulate unit
`timescale 1ns/1ps
`include "mac_defines.svh"
module tb;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic exec_i = 1'b0;
	logic load_i = 1'b0;
	logic [15:0] opcode_i = 16'h0000;
	logic [15:0] stream_data_i = 16'h0000;
	logic [15:0] ld_top = 16'h0000;
	logic [15:0] ld_next = 16'h0000;
	logic [15:0] top, nxt, ext, mid, low, stk_top;
	logic push, pop, top_we, active, from_bus, hold;
	int errors = 0;
	int check_count = 0;
	always #20 clk_i = ~clk_i;
	mac_unit i_dut (.clk_i, .rst_n_i, .exec_i, .opcode_i, .top_i(top), .next_i(nxt),
		.stream_data_i, .acc_ext_word_o(ext), .acc_mid_word_o(mid), .acc_low_word_o(low),
		.stack_push_o(push), .stack_pop_o(pop), .stack_top_o(stk_top),
		.stack_top_we_o(top_we), .stream_active_o(active), .stream_from_bus_o(from_bus),
		.int_hold_o(hold));
	mac_stack_model i_stk (.clk_i, .rst_n_i, .load_i, .load_top_i(ld_top),
		.load_next_i(ld_next), .push_i(push), .pop_i(pop), .top_we_i(top_we),
		.new_top_i(stk_top), .top_o(top), .next_o(nxt));
	task chk(input logic [47:0] got, input logic [47:0] exp);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task report_and_stop;
		$display("errors=%0d checks=%0d", errors, check_count);
		if (errors == 0 && check_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task set_stack(input logic [15:0] t, input logic [15:0] n);
		@(negedge clk_i);
		load_i = 1'b1;
		ld_top = t;
		ld_next = n;
		@(negedge clk_i);
		load_i = 1'b0;
	endtask
	task run(input logic [15:0] op);
		@(negedge clk_i);
		exec_i = 1'b1;
		opcode_i = op;
		@(negedge clk_i);
		exec_i = 1'b0;
	endtask
	task arith_table;
		logic [15:0] ops [8];
		logic [47:0] exps [8];
		ops = '{`MAC_OPC_PROD_SUB, `MAC_OPC_RSHIFT, `MAC_OPC_ACC_SIGNED, `MAC_OPC_ACC_MIXED,
			`MAC_OPC_ACC_UNSIGNED, `MAC_OPC_PROD_SIGNED, `MAC_OPC_PROD_MIXED,
			`MAC_OPC_PROD_UNSIGNED};
		exps = '{48'hFFFF_FFFF_FFFE, 48'hFFFF_FFFF_FFFF, 48'h0000_0000_0001,
			48'hFFFF_FFFE_0003, 48'h0000_FFFB_0005, 48'h0000_0000_0002,
			48'h0000_FFFE_0002, 48'h0000_FFFD_0002};
		set_stack(16'hFFFE, 16'hFFFF);
		for (int i = 0; i < 8; i++) begin
			run(ops[i]);
			chk({ext, mid, low}, exps[i]);
			chk(hold, i >= 5);
			chk({push, pop, top_we}, 3'h0);
		end
		chk({top, nxt}, 32'hFFFE_FFFF);
	endtask
	task stack_ops;
		set_stack(16'hA5C3, 16'h1234);
		run(`MAC_OPC_WR_EXT);
		chk({ext, pop, push, top_we}, {16'hA5C3, 3'b100});
		run(`MAC_OPC_RD_EXT);
		chk({top, nxt}, 32'h1234_0000);
		chk({push, top_we, stk_top}, {2'b11, 16'hA5C3});
		run(`MAC_OPC_RD_MID);
		chk({top, nxt}, 32'hA5C3_1234);
		chk({push, top_we, hold, stk_top}, {3'b011, 16'hFFFD});
	endtask
	task leading_zero_normalise_shift;
		set_stack(16'h0003, 16'h8000);
		run(`MAC_OPC_LEADING_ZERO_NORMALISE);
		chk({ext, mid, low}, 48'h000E_E000_0000);
		run(`MAC_OPC_RSHIFT | 16'h0120);
		chk({ext, mid, low}, 48'h0000_000E_E000);
	endtask
	task stream_mac;
		set_stack(16'h0010, 16'h0005);
		stream_data_i = 16'h0003;
		@(negedge clk_i);
		exec_i = 1'b1;
		opcode_i = `MAC_OPC_STREAM_BUS;
		@(negedge clk_i);
		opcode_i = 16'h0000;
		chk({hold, from_bus, push, pop, top_we}, 5'b11000);
		@(negedge clk_i);
		opcode_i = `MAC_OPC_FETCH;
		chk(active, 1'b1);
		@(negedge clk_i);
		exec_i = 1'b0;
		chk({ext, mid, low}, 48'h0000_000E_E00F);
		run(16'h0000);
		chk(active, 1'b0);
		run(`MAC_OPC_FETCH);
		chk({ext, mid, low}, 48'h0000_000E_E00F);
		run(`MAC_OPC_STREAM_STK);
		chk({hold, push, pop, top_we, mid}, {4'h0, 16'h000E});
	endtask
	initial begin
		#400000;
		errors++;
		report_and_stop;
	end
	initial begin
		repeat (5) @(negedge clk_i);
		rst_n_i = 1'b1;
		arith_table;
		stack_ops;
		leading_zero_normalise_shift;
		stream_mac;
		report_and_stop;
	end
endmodule
